// ### hdl/pmbus_status_regs.sv
// Channel status registers, temperature settings and limit checking
`timescale 1ns/1ps
`include "pmbus_status_cfg.svh"

module pmbus_status_regs (
    // Clock and reset
    input  wire logic                            clk_sys,
    input  wire logic                            rst,
    // Decoded command port
    input  wire logic                            cmd_valid,
    input  wire logic                            cmd_write,
    input  wire logic [7:0]                      cmd_code,
    input  wire logic                            cmd_page,
    input  wire logic [15:0]                     cmd_wdata,
    // Read answer
    output logic                                 rsp_valid,
    output logic                                 rsp_known,
    output logic [15:0]                          rsp_data,
    // Per-channel conditions
    input  wire pmbus_status_pkg::chan_evt_s     [1:0] chan_evt,
    input  wire pmbus_status_pkg::temp_sample_s  [1:0] temp_fault_bus_sense,
    // Shared conditions
    input  wire logic [7:0]                      input_evt,
    input  wire logic [7:0]                      cml_evt,
    input  wire logic [15:0]                     pad_state_word,
    input  wire logic [7:0]                      common_device_flags,
    input  wire logic [15:0]                     vendor_info_word,
    // Alert request, before any mask
    output logic                                 alert_req
);

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------

    // Linear word to signed fixed point with eight fraction bits
    function automatic logic signed [47:0] l11_fx(input logic [15:0] w);
        logic signed [47:0] m;
        logic signed [5:0]  sh;
        m  = 48'(signed'(w[10:0]));
        sh = 6'(signed'(w[15:11])) + 6'(`L11_FRAC);
        if (sh >= 0) begin
            l11_fx = m <<< sh;
        end else begin
            l11_fx = m >>> (-sh);
        end
    endfunction

    // True when the reading lies strictly above the limit
    function automatic logic over_limit(input logic [15:0] mv, input logic [15:0] slope,
        input logic [15:0] zoff, input logic [15:0] lim);
        logic signed [47:0] diff;
        logic signed [95:0] lhs;
        logic signed [95:0] rhs;
        diff = (48'(signed'({1'b0, mv})) <<< `L11_FRAC) - l11_fx(zoff);
        lhs  = 96'(diff) <<< `L11_FRAC;
        rhs  = 96'(l11_fx(lim)) * 96'(l11_fx(slope));
        over_limit = lhs > rhs; // see RQ26
    endfunction

    // Summary byte of one channel
    function automatic logic [7:0] sum_byte(input pmbus_status_pkg::chan_st_s c,
        input logic on, input logic [7:0] cml);
        sum_byte[7] = c.busy; // see RQ7
        sum_byte[6] = ~on; // see RQ8
        sum_byte[5] = c.vout[7]; // see RQ9
        sum_byte[4] = c.iout[7]; // see RQ10
        sum_byte[3] = 1'b0; // see RQ10
        sum_byte[2] = |c.temp; // see RQ4
        sum_byte[1] = |cml; // see RQ10
        sum_byte[0] = c.other; // see RQ11
    endfunction

    // Summary word of one channel
    function automatic logic [15:0] sum_word(input pmbus_status_pkg::chan_st_s c,
        input logic on, input logic pg, input logic [7:0] cml, input logic [7:0] inp);
        sum_word[15]   = (|c.vout) | c.pstage; // see RQ13
        sum_word[14]   = (|c.iout) | c.pstage; // see RQ14
        sum_word[13]   = |inp; // see RQ15
        sum_word[12]   = |c.dev; // see RQ15
        sum_word[11]   = ~pg; // see RQ16
        sum_word[10:8] = 3'h0; // see RQ17
        sum_word[7:0]  = sum_byte(c, on, cml); // see RQ12
    endfunction

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    pmbus_status_pkg::state_s st_ff;      // Registered state
    pmbus_status_pkg::state_s nxt_st;     // Next state

    // Command strobes, not yet qualified by the selected page
    logic wr;                             // Write command this cycle
    logic rd;                             // Read command this cycle
    logic clr_all;                        // Global clear this cycle

    assign wr      = cmd_valid & cmd_write;
    assign rd      = cmd_valid & ~cmd_write;
    assign clr_all = wr & (cmd_code == `CMD_CLEAR_FAULTS); // see RQ21

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    // Each sticky bit takes its clear first and its live set last, so an
    // event in the same cycle as a clear is never lost and a condition
    // that is still present reappears at once after the global clear, except the temperature bits, which wait for the next sample compare.
    always_comb begin
        logic [7:0]  vset;
        logic [7:0]  wclr;
        logic        sel;
        logic [15:0] rdat;
        logic        known;
        pmbus_status_pkg::chan_evt_s e;
        nxt_st = st_ff;
        vset   = 8'h00;
        wclr   = 8'h00;
        sel    = 1'b0;
        rdat   = 16'h0000;
        known  = 1'b0;
        e      = chan_evt[0];

        // Per-channel registers
        for (int i = 0; i < 2; i++) begin
            e   = chan_evt[i];
            sel = wr & (cmd_page == 1'(i));

            // Paged settings, stored as written linear words
            if (sel && cmd_code == `CMD_TEMP_SLOPE) begin
                nxt_st.ch[i].slope = cmd_wdata; // see RQ1, RQ5
            end
            if (sel && cmd_code == `CMD_TEMP_ZERO_OFFSET) begin
                nxt_st.ch[i].zoff = cmd_wdata; // see RQ2, RQ5
            end
            if (sel && cmd_code == `CMD_EXT_OVERTEMP_FAULT_LIMIT) begin
                nxt_st.ch[i].otf = cmd_wdata; // see RQ3, RQ5
            end
            if (sel && cmd_code == `CMD_EXT_OVERTEMP_WARN_LIMIT) begin
                nxt_st.ch[i].otw = cmd_wdata; // see RQ4, RQ5
            end

            // Busy bit, write-one clear through byte or word
            wclr = 8'h00;
            if (sel && (cmd_code == `CMD_FAULT_SUM_BYTE ||
                        cmd_code == `CMD_FAULT_SUM_WORD)) begin
                wclr[0] = cmd_wdata[`SUM_BUSY_BIT];
            end
            if (clr_all || wclr[0]) begin
                nxt_st.ch[i].busy = 1'b0; // see RQ7
            end
            if (e.busy) begin
                nxt_st.ch[i].busy = 1'b1; // see RQ7, RQ25
            end

            // Other fault and power stage flags clear only globally
            if (clr_all) begin
                nxt_st.ch[i].other  = 1'b0; // see RQ23
                nxt_st.ch[i].pstage = 1'b0;
            end
            if (e.other) begin
                nxt_st.ch[i].other = 1'b1; // see RQ11, RQ25
            end
            if (e.pstage) begin
                nxt_st.ch[i].pstage = 1'b1; // see RQ14
            end

            // Output voltage status
            vset[7] = e.vout_ov | e.pstage | e.sense_open; // see RQ18
            vset[6] = e.vout_ov_warn; // see RQ18
            vset[5] = e.vout_uv_warn; // see RQ18
            vset[4] = e.vout_uv_fault | e.sense_open; // see RQ18
            vset[3] = e.max_output_voltage_warning; // see RQ19
            vset[2] = e.rise_time_exceeded_fault; // see RQ19
            vset[1:0] = 2'h0; // see RQ19
            wclr = (sel && cmd_code == `CMD_VOUT_STATUS) ? cmd_wdata[7:0] : 8'h00;
            wclr = clr_all ? 8'hff : wclr;
            nxt_st.ch[i].vout = ((st_ff.ch[i].vout & ~wclr) | vset) & `MASK_VOUT; // see RQ20, RQ25

            // Output current status, layout owned elsewhere
            wclr = (sel && cmd_code == `CMD_IOUT_STATUS) ? cmd_wdata[7:0] : 8'h00;
            wclr = clr_all ? 8'hff : wclr;
            nxt_st.ch[i].iout = ((st_ff.ch[i].iout & ~wclr) | e.iout_evt) & `MASK_IOUT; // see RQ25

            // Device-specific status
            wclr = (sel && cmd_code == `CMD_DEV_STATUS) ? cmd_wdata[7:0] : 8'h00;
            wclr = clr_all ? 8'hff : wclr;
            nxt_st.ch[i].dev = ((st_ff.ch[i].dev & ~wclr) | e.dev_evt) & `MASK_DEV; // see RQ25

            // Temperature sample, compared one cycle after capture
            nxt_st.ch[i].tpend = temp_fault_bus_sense[i].valid;
            if (temp_fault_bus_sense[i].valid) begin
                nxt_st.ch[i].tmv = temp_fault_bus_sense[i].mv;
            end
            wclr = (sel && cmd_code == `CMD_TEMP_STATUS) ? cmd_wdata[7:0] : 8'h00;
            wclr = clr_all ? 8'hff : wclr;
            nxt_st.ch[i].temp = st_ff.ch[i].temp & ~wclr[7:6]; // see RQ24
            if (st_ff.ch[i].tpend && over_limit(st_ff.ch[i].tmv, st_ff.ch[i].slope,
                    st_ff.ch[i].zoff, st_ff.ch[i].otf)) begin
                nxt_st.ch[i].temp[`TEMP_FAULT_BIT] = 1'b1; // see RQ3, RQ24
            end
            if (st_ff.ch[i].tpend && over_limit(st_ff.ch[i].tmv, st_ff.ch[i].slope,
                    st_ff.ch[i].zoff, st_ff.ch[i].otw)) begin
                nxt_st.ch[i].temp[`TEMP_WARN_BIT] = 1'b1; // see RQ4, RQ24
            end
        end

        // Shared input and communication status bytes
        wclr = (wr && cmd_code == `CMD_INPUT_STATUS) ? cmd_wdata[7:0] : 8'h00;
        wclr = clr_all ? 8'hff : wclr;
        nxt_st.input_st = ((st_ff.input_st & ~wclr) | input_evt) & `MASK_INPUT; // see RQ6
        wclr = (wr && cmd_code == `CMD_CML_STATUS) ? cmd_wdata[7:0] : 8'h00;
        wclr = clr_all ? 8'hff : wclr;
        nxt_st.cml_st = ((st_ff.cml_st & ~wclr) | cml_evt) & `MASK_CML; // see RQ6

        // Read decode; vendor words have no write path at all
        known = 1'b1;
        case (cmd_code)
            `CMD_TEMP_SLOPE:       rdat = st_ff.ch[cmd_page].slope;
            `CMD_TEMP_ZERO_OFFSET: rdat = st_ff.ch[cmd_page].zoff;
            `CMD_EXT_OVERTEMP_FAULT_LIMIT:   rdat = st_ff.ch[cmd_page].otf;
            `CMD_EXT_OVERTEMP_WARN_LIMIT:    rdat = st_ff.ch[cmd_page].otw;
            `CMD_FAULT_SUM_BYTE: begin
                rdat = {8'h00, sum_byte(st_ff.ch[cmd_page],
                    chan_evt[cmd_page].output_on, st_ff.cml_st)};
            end
            `CMD_FAULT_SUM_WORD: begin
                rdat = sum_word(st_ff.ch[cmd_page], chan_evt[cmd_page].output_on,
                    chan_evt[cmd_page].power_good, st_ff.cml_st, st_ff.input_st);
            end
            `CMD_VOUT_STATUS:      rdat = {8'h00, st_ff.ch[cmd_page].vout};
            `CMD_IOUT_STATUS:      rdat = {8'h00, st_ff.ch[cmd_page].iout};
            `CMD_INPUT_STATUS:     rdat = {8'h00, st_ff.input_st};     // see RQ6
            `CMD_TEMP_STATUS:      rdat = {8'h00, st_ff.ch[cmd_page].temp, 6'h00};
            `CMD_CML_STATUS:       rdat = {8'h00, st_ff.cml_st};       // see RQ6
            `CMD_DEV_STATUS:       rdat = {8'h00, st_ff.ch[cmd_page].dev};
            `CMD_PAD_STATE:        rdat = pad_state_word;              // see RQ22
            `CMD_COMMON_FLAGS:     rdat = {8'h00, common_device_flags}; // see RQ22
            `CMD_VENDOR_INFO:      rdat = vendor_info_word;            // see RQ22
            default: begin
                rdat  = 16'h0000;
                known = 1'b0;
            end
        endcase
        nxt_st.rsp_valid = rd;
        nxt_st.rsp_known = rd & known;
        nxt_st.rsp_data  = rd ? rdat : 16'h0000;

        // Alert follows every sticky bit of either channel except pstage, and the shared bytes
        nxt_st.alert = (|nxt_st.input_st) | (|nxt_st.cml_st);  // see RQ23
        for (int i = 0; i < 2; i++) begin
            nxt_st.alert = nxt_st.alert | nxt_st.ch[i].busy | nxt_st.ch[i].other
                | (|nxt_st.ch[i].vout) | (|nxt_st.ch[i].iout) | (|nxt_st.ch[i].temp)
                | (|nxt_st.ch[i].dev); // see RQ4, RQ20
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
            for (int i = 0; i < 2; i++) begin
                st_ff.ch[i].slope <= `RST_TEMP_SLOPE;          // see RQ1
                st_ff.ch[i].zoff  <= `RST_TEMP_ZERO_OFFSET;    // see RQ2
                st_ff.ch[i].otf   <= `RST_EXT_OVERTEMP_FAULT_LIMIT;      // see RQ3
                st_ff.ch[i].otw   <= `RST_EXT_OVERTEMP_WARN_LIMIT;
            end
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign rsp_valid = st_ff.rsp_valid;
    assign rsp_known = st_ff.rsp_known;
    assign rsp_data  = st_ff.rsp_data;
    assign alert_req = st_ff.alert;

endmodule

// ### hdl/pmbus_status_cfg.svh
// Constants for the channel status and external temperature limit block
// How it works
// RQ1: Paged slope setting, default encoded value
// RQ2: Paged zero-degree offset, default 600 mV
// RQ3: Fault when temperature passes fault limit
// RQ4: Warning sets temp summary, status, alert
// RQ5: Settings are two-byte linear 5s/11s words
// RQ6: Input, comm status, vendor words shared
// RQ7: Busy bit sticky, cleared by one
// RQ8: Off bit reads one when no power
// RQ9: Overvoltage summary on OV, stage, open sense
// RQ10: Overcurrent, zero, temperature, comm summary bits
// RQ11: Bit zero flags any other fault
// RQ12: Word low byte equals status byte
// RQ13: Bit 15 output voltage, stage, sense
// RQ14: Bit 14 output current or stage
// RQ15: Bit 13 input, bit 12 vendor
// RQ16: Bit 11 high when power not good
// RQ17: Bits 10 to 8 read zero
// RQ18: Voltage status bits seven to four
// RQ19: Max, rise-time bits; bits 1:0 zero
// RQ20: Voltage bits 7:2 alert, write-one clear
// RQ21: Clear command clears all fault bits
// RQ22: Vendor words read-only, writes ignored
// RQ23: Clear releases alert, live faults reassert
// RQ24: Temperature status bits seven and six
// RQ25: Status bits stay set until cleared
// RQ26: Exceeded only when strictly greater
`ifndef PMBUS_STATUS_CFG_SVH
`define PMBUS_STATUS_CFG_SVH

// ---------------------------------------------------------------
// Command codes
// ---------------------------------------------------------------
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_EXT_OVERTEMP_FAULT_LIMIT 8'h4f
`define CMD_EXT_OVERTEMP_WARN_LIMIT 8'h51
`define CMD_FAULT_SUM_BYTE 8'h78
`define CMD_FAULT_SUM_WORD 8'h79
`define CMD_VOUT_STATUS 8'h7a
`define CMD_IOUT_STATUS 8'h7b
`define CMD_INPUT_STATUS 8'h7c
`define CMD_TEMP_STATUS 8'h7d
`define CMD_CML_STATUS 8'h7e
`define CMD_DEV_STATUS 8'h80
`define CMD_VENDOR_INFO 8'hb6
`define CMD_PAD_STATE 8'he5
`define CMD_COMMON_FLAGS 8'hef
`define CMD_TEMP_SLOPE 8'hf8
`define CMD_TEMP_ZERO_OFFSET 8'hf9

// ---------------------------------------------------------------
// Reset values of the paged settings
// ---------------------------------------------------------------
`define RST_TEMP_SLOPE 16'hd200
`define RST_TEMP_ZERO_OFFSET 16'h0258
`define RST_EXT_OVERTEMP_FAULT_LIMIT 16'heb20
`define RST_EXT_OVERTEMP_WARN_LIMIT 16'heaa8

// ---------------------------------------------------------------
// Supported bits of each status byte
// ---------------------------------------------------------------
`define MASK_VOUT 8'hfc
`define MASK_IOUT 8'ha8
`define MASK_INPUT 8'ha8
`define MASK_CML 8'hfb
`define MASK_DEV 8'hfb

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SUM_BUSY_BIT 7
`define TEMP_FAULT_BIT 1
`define TEMP_WARN_BIT 0
`define L11_FRAC 8

`endif

// ### hdl/pmbus_status_pkg.sv
// Types shared by the channel status and temperature limit block
package pmbus_status_pkg;

    // Live conditions of one channel, from the control logic
    typedef struct packed {
        logic       busy;          // Could not respond
        logic       other;         // Fault not in the summary
        logic       vout_ov;       // Output overvoltage fault
        logic       pstage;        // Power stage fault
        logic       sense_open;    // Open positive output sense
        logic       vout_ov_warn;  // Overvoltage warning
        logic       vout_uv_warn;  // Undervoltage warning
        logic       vout_uv_fault; // Undervoltage fault
        logic       max_output_voltage_warning;
        logic       rise_time_exceeded_fault;
        logic       output_on;     // Delivering output power
        logic       power_good;    // Power good level
        logic [7:0] iout_evt;      // Current status events
        logic [7:0] dev_evt;       // Device-specific events
    } chan_evt_s;

    // Temperature sense sample of one channel
    typedef struct packed {
        logic        valid;        // One-cycle strobe
        logic [15:0] mv;           // Reading in millivolts
    } temp_sample_s;

    // Register state of one channel
    typedef struct packed {
        logic [15:0] slope;
        logic [15:0] zoff;
        logic [15:0] otf;
        logic [15:0] otw;
        logic        busy;
        logic        other;
        logic [7:0]  vout;
        logic [7:0]  iout;
        logic [1:0]  temp;
        logic [7:0]  dev;
        logic        pstage;
        logic        tpend;
        logic [15:0] tmv;
    } chan_st_s;

    // Whole state of the block
    typedef struct packed {
        chan_st_s [1:0] ch;
        logic [7:0]     input_st;
        logic [7:0]     cml_st;
        logic           rsp_valid;
        logic           rsp_known;
        logic [15:0]    rsp_data;
        logic           alert;
    } state_s;

endpackage

// ### sim/pmbus_status_props.sv
// Port-level checks for the status and temperature limit block
`timescale 1ns/1ps
module pmbus_status_props (
    // Clock and reset
    input wire logic                                 clk_sys,
    input wire logic                                 rst,
    // Command and answer
    input wire logic                                 cmd_valid,
    input wire logic                                 cmd_write,
    input wire logic [7:0]                           cmd_code,
    input wire logic                                 cmd_page,
    input wire logic                                 rsp_valid,
    input wire logic [15:0]                          rsp_data,
    // Conditions and alert
    input wire pmbus_status_pkg::chan_evt_s [1:0]    chan_evt,
    input wire pmbus_status_pkg::temp_sample_s [1:0] temp_fault_bus_sense,
    input wire logic [7:0]                           input_evt,
    input wire logic [7:0]                           cml_evt,
    input wire logic [15:0]                          pad_state_word,
    input wire logic                                 alert_req
);
    logic quiet; // No event source is active
    // Flags sit in bits 27:18, current and device events in 15:0
    always_comb begin
        quiet = (input_evt == 8'h00) && (cml_evt == 8'h00);
        for (int i = 0; i < 2; i++) begin
            quiet &= (chan_evt[i][27:18] == 10'h000) && (chan_evt[i][15:0] == 16'h0000);
            quiet &= !temp_fault_bus_sense[i].valid;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Read and write of one command code
    sequence s_rd(logic [7:0] c);
        cmd_valid && !cmd_write && cmd_code == c;
    endsequence
    sequence s_wr(logic [7:0] c);
        cmd_valid && cmd_write && cmd_code == c;
    endsequence
    AST_READ_ANSWER: assert property (cmd_valid && !cmd_write |=> rsp_valid)
        else $error("read without answer");
    AST_WRITE_SILENT: assert property (cmd_valid && cmd_write |=> !rsp_valid)
        else $error("answer after a write");
    AST_IDLE_ZERO: assert property (!rsp_valid |-> rsp_data == 16'h0000)
        else $error("data without answer");
    AST_BYTE_ZERO: assert property (s_rd(8'h78) |=> rsp_data[15:8] == 8'h00 && !rsp_data[3])
        else $error("summary byte reserved bits set");
    AST_WORD_ZERO: assert property (s_rd(8'h79) |=> rsp_data[10:8] == 3'h0 && !rsp_data[3])
        else $error("summary word unused bits set");
    AST_VOUT_ZERO: assert property (s_rd(8'h7a) |=> rsp_data[1:0] == 2'h0)
        else $error("voltage status low bits set");
    AST_OFF_BIT: assert property (s_rd(8'h78) ##0 !chan_evt[cmd_page].output_on |=> rsp_data[6])
        else $error("off bit clear while off");
    AST_PG_BIT: assert property (s_rd(8'h79) ##0 !chan_evt[cmd_page].power_good |=> rsp_data[11])
        else $error("power bad bit clear");
    AST_PAD_RO: assert property (s_rd(8'he5) |=> rsp_data == $past(pad_state_word))
        else $error("pad word differs");
    AST_STICKY: assert property (alert_req && !(cmd_valid && cmd_write) |=> alert_req)
        else $error("alert dropped without clear");
    AST_CLEAR_RELEASE: assert property (s_wr(8'h03) ##0 (quiet && $past(quiet)) |=> !alert_req)
        else $error("alert kept after clear");
endmodule
bind pmbus_status_regs pmbus_status_props u_props (.clk_sys(clk_sys), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_page(cmd_page),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .chan_evt(chan_evt),
    .temp_fault_bus_sense(temp_fault_bus_sense), .input_evt(input_evt), .cml_evt(cml_evt),
    .pad_state_word(pad_state_word), .alert_req(alert_req));

// ### sim/pmbus_host_model.sv
// Host model that issues commands and takes the answers
`timescale 1ns/1ps
module pmbus_host_model (
    // Clock
    input wire logic        clk_sys,
    // Command to the device
    output logic            cmd_valid,
    output logic            cmd_write,
    output logic [7:0]      cmd_code,
    output logic            cmd_page,
    output logic [15:0]     cmd_wdata,
    // Answer from the device
    input wire logic        rsp_valid,
    input wire logic        rsp_known,
    input wire logic [15:0] rsp_data
);
    // Idle until the first command
    initial begin
        {cmd_valid, cmd_write, cmd_code, cmd_page, cmd_wdata} = '0;
    end
    // One whole word per command; the answer is taken one cycle after
    task automatic xfer(input logic w, input logic [7:0] c, input logic p,
                        input logic [15:0] wd, output logic [1:0] vk, output logic [15:0] rd);
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_code = c;
        cmd_page = p;
        cmd_wdata = wd;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        cmd_code = ~c; // Released lines must not look like a valid command
        cmd_wdata = ~wd;
        vk = {rsp_valid, rsp_known};
        rd = rsp_data;
    endtask
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the status and temperature limit block
`timescale 1ns/1ps
module tb_top;
    logic                                 clk_sys = 1'b0;
    logic                                 rst = 1'b1;
    logic                                 cmd_valid, cmd_write, cmd_page;
    logic [7:0]                           cmd_code, input_evt, cml_evt;
    logic [15:0]                          cmd_wdata, rsp_data;
    logic                                 rsp_valid, rsp_known, alert_req;
    pmbus_status_pkg::chan_evt_s [1:0]    chan_evt;
    pmbus_status_pkg::temp_sample_s [1:0] tsense;
    int                                   n_mismatch = 0;
    int                                   comparisons = 0;
    // Row: code, page, expected data, expected known flag
    typedef struct packed {logic [7:0] code; logic pg; logic [15:0] exp; logic known;} row_s;
    row_s rows [13] = '{'{8'hf8, 0, 16'hd200, 1}, '{8'hf9, 1, 16'h0258, 1},
        '{8'h4f, 0, 16'heb20, 1}, '{8'h51, 1, 16'heaa8, 1}, '{8'h78, 0, 16'h0000, 1},
        '{8'h78, 1, 16'h0040, 1}, '{8'h79, 1, 16'h0840, 1}, '{8'h79, 0, 16'h0000, 1},
        '{8'he5, 0, 16'h5a3c, 1}, '{8'hef, 0, 16'h006c, 1}, '{8'hb6, 1, 16'h0020, 1},
        '{8'h01, 0, 16'h0000, 0}, '{8'h03, 0, 16'h0000, 0}};
    // Event bit of channel 0, voltage status and summary word it should give
    int          ev_bit [10] = '{25, 24, 23, 22, 21, 20, 19, 18, 15, 7};
    logic [7:0]  ev_vout [10] = '{8'h80, 8'h80, 8'h90, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 0, 0};
    logic [15:0] ev_word [10] = '{16'h8020, 16'hc020, 16'h8020, 16'h8000, 16'h8000, 16'h8000,
        16'h8000, 16'h8000, 16'h4010, 16'h1000};
    always #2.5 clk_sys = ~clk_sys;
    pmbus_status_regs dut (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_known(rsp_known), .rsp_data(rsp_data), .chan_evt(chan_evt),
        .temp_fault_bus_sense(tsense), .input_evt(input_evt), .cml_evt(cml_evt),
        .pad_state_word(16'h5a3c), .common_device_flags(8'h6c), .vendor_info_word(16'h0020),
        .alert_req(alert_req));
    pmbus_host_model host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_known(rsp_known), .rsp_data(rsp_data));
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task rd(input logic [7:0] c, input logic p, input logic [15:0] e, input logic k);
        logic [1:0]  vk;
        logic [15:0] d;
        host.xfer(1'b0, c, p, 16'h0000, vk, d);
        chk($sformatf("flags %h", c), {14'h0000, vk}, {14'h0000, 1'b1, k});
        chk($sformatf("data %h", c), d, e);
    endtask
    task wr(input logic [7:0] c, input logic p, input logic [15:0] wd);
        logic [1:0]  vk;
        logic [15:0] d;
        host.xfer(1'b1, c, p, wd, vk, d);
    endtask
    // One-cycle event on channel 0; the sticky bit must outlive it
    task pulse(input int b);
        @(negedge clk_sys) chan_evt[0][b] = 1'b1;
        @(negedge clk_sys) chan_evt[0][b] = 1'b0;
    endtask
    // Sample strobe, then one spare cycle for the limit compare
    task temp(input logic [15:0] mv);
        @(negedge clk_sys) tsense[0] = {1'b1, mv};
        @(negedge clk_sys) tsense[0].valid = 1'b0;
        @(negedge clk_sys);
    endtask
    task tally_and_finish;
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        chan_evt = '0;
        chan_evt[0].output_on = 1'b1;
        chan_evt[0].power_good = 1'b1;
        tsense = '0;
        input_evt = 8'h00;
        cml_evt = 8'h00;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys) rst = 1'b0;
        chk("alert", {15'h0000, alert_req}, 16'h0000);
        foreach (rows[i]) rd(rows[i].code, rows[i].pg, rows[i].exp, rows[i].known);
        $display("done table");
        temp(16'd1280);
        rd(8'h7d, 0, 16'h0000, 1);
        temp(16'd1281);
        rd(8'h7d, 0, 16'h0040, 1);
        rd(8'h78, 0, 16'h0004, 1);
        temp(16'd1400);
        rd(8'h7d, 0, 16'h0040, 1);
        temp(16'd1401);
        rd(8'h7d, 0, 16'h00c0, 1);
        wr(8'h7d, 0, 16'h0040);
        rd(8'h7d, 0, 16'h0080, 1);
        wr(8'h03, 0, 16'h0000);
        rd(8'h7d, 0, 16'h0000, 1);
        $display("done temperature");
        for (int i = 0; i < 10; i++) begin
            pulse(ev_bit[i]);
            chk("alert", {15'h0000, alert_req}, 16'h0001);
            rd(8'h7a, 0, {8'h00, ev_vout[i]}, 1);
            rd(8'h79, 0, ev_word[i], 1);
            wr(8'h03, 0, 16'h0000);
            rd(8'h7a, 0, 16'h0000, 1);
        end
        $display("done events");
        pulse(25);
        wr(8'h7a, 0, 16'h0080);
        rd(8'h7a, 0, 16'h0000, 1);
        pulse(27);
        rd(8'h78, 0, 16'h0080, 1);
        wr(8'h78, 0, 16'h0080);
        rd(8'h78, 0, 16'h0000, 1);
        pulse(26);
        rd(8'h78, 0, 16'h0001, 1);
        @(negedge clk_sys) chan_evt[0].vout_uv_warn = 1'b1;
        wr(8'h03, 0, 16'h0000);
        rd(8'h7a, 0, 16'h0020, 1);
        @(negedge clk_sys) chan_evt[0].vout_uv_warn = 1'b0;
        wr(8'h03, 0, 16'h0000);
        chk("alert", {15'h0000, alert_req}, 16'h0000);
        $display("done clears");
        @(negedge clk_sys) {input_evt, cml_evt} = 16'h8080;
        @(negedge clk_sys) {input_evt, cml_evt} = 16'h0000;
        rd(8'h79, 1, 16'h2842, 1);
        rd(8'h79, 0, 16'h2002, 1);
        wr(8'h03, 0, 16'h0000);
        wr(8'he5, 0, 16'hffff);
        rd(8'he5, 0, 16'h5a3c, 1);
        wr(8'hf8, 1, 16'h1234);
        rd(8'hf8, 1, 16'h1234, 1);
        rd(8'hf8, 0, 16'hd200, 1);
        $display("done shared and paged");
        tally_and_finish;
    end
    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        tally_and_finish;
    end
endmodule
